// ===== dual_slope_phase_sequencer.sv
// Purpose: phase sequencing and switch control of a dual-slope converter
// Assumes: comparator_positive is synchronous to clk, high while integrator is above zero
// Notes: free-running; the frame counter restarts each cycle after the full period
`timescale 1ns/100ps
module dual_slope_phase_sequencer
	import phase_seq_pkg::*;
#(
	parameter int CYCLE     = CYCLE_CLOCKS,
	parameter int INT_LEN   = INT_CLOCKS,
	parameter int REF_MAX   = REF_MAX_CLOCKS,
	parameter int OVER_LIM  = OVER_LIMIT,
	parameter int DIS_LEN   = DISCH_CLOCKS,
	parameter int DIS_OVER  = DISCH_OVER_CLOCKS
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             comparator_positive,
	output logic                  offset_null_phase,
	output logic                  signal_integrate_phase,
	output logic                  reference_integrate_phase,
	output logic                  integrator_discharge_phase,
	output logic                  inputs_shorted_to_common,
	output logic                  analog_input_high_to_pin,
	output logic                  analog_input_low_to_pin,
	output logic                  analog_input_low_to_common,
	output logic                  ref_cap_charge,
	output logic                  ref_cap_connect_pos,
	output logic                  ref_cap_connect_neg,
	output logic                  offset_storage_capacitor_loop,
	output logic                  discharge_loop,
	output logic                  polarity,
	output logic                  busy,
	output logic                  overrange,
	output logic [CNT_W-1:0]      result_count,
	output logic                  result_valid
);
	phase_e           phase_q;
	phase_e           phase_d;
	logic [CNT_W-1:0] frame_q;
	logic [CNT_W-1:0] frame_d;
	logic [CNT_W-1:0] ref_cnt_q;
	logic [CNT_W-1:0] ref_cnt_d;
	logic             pol_q;
	logic             pol_d;
	logic             over_q;
	logic             over_d;
	logic             busy_q;
	logic             busy_d;
	logic [CNT_W-1:0] result_q;
	logic [CNT_W-1:0] result_d;
	logic             valid_q;
	logic             valid_d;
	logic             cmp_q;
	logic             tmr_load;
	logic [CNT_W-1:0] tmr_val;
	logic             tmr_done;
	logic             crossing;
	logic             frame_end;

	phase_timer #(
		.W(CNT_W)
	) u_timer (
		.clk      (clk),
		.srst     (srst),
		.load     (tmr_load),
		.load_val (tmr_val),
		.done     (tmr_done)
	);

	// comparator registered once per clock
	always_ff @(posedge clk) begin
		if (srst) begin
			cmp_q <= 1'b0;
		end else begin
			cmp_q <= comparator_positive; // R16
		end
	end

	// zero crossing: integrator sign flipped away from the latched polarity
	assign crossing  = (cmp_q != pol_q); // R9
	assign frame_end = (frame_q == CNT_W'(CYCLE - 1)); // R13

	always_comb begin
		phase_d   = phase_q;
		frame_d   = frame_end ? '0 : frame_q + CNT_W'(1);
		ref_cnt_d = ref_cnt_q;
		pol_d     = pol_q;
		over_d    = over_q;
		busy_d    = busy_q;
		result_d  = result_q;
		valid_d   = 1'b0;
		tmr_load  = 1'b0;
		tmr_val   = '0;
		case (phase_q)
			PH_NULL: begin
				// null absorbs leftover time so cycles start every period
				if (frame_end) begin // R13
					phase_d  = PH_SIG; // R1
					busy_d   = 1'b1; // R14
					tmr_load = 1'b1;
					tmr_val  = CNT_W'(INT_LEN); // R5
				end
			end
			PH_SIG: begin
				if (tmr_done) begin
					phase_d   = PH_REF; // R1
					pol_d     = cmp_q; // R6
					over_d    = 1'b0;
					ref_cnt_d = '0;
				end
			end
			PH_REF: begin
				ref_cnt_d = ref_cnt_q + CNT_W'(1); // R9
				if (crossing) begin
					phase_d  = PH_DIS; // R1
					busy_d   = 1'b0; // R14
					result_d = ref_cnt_q;
					valid_d  = 1'b1;
					tmr_load = 1'b1;
					tmr_val  = CNT_W'(DIS_LEN); // R11
				end else if (ref_cnt_q >= CNT_W'(OVER_LIM)) begin
					phase_d  = PH_DIS;
					over_d   = 1'b1; // R15
					busy_d   = 1'b0; // R14
					result_d = ref_cnt_q;
					valid_d  = 1'b1;
					tmr_load = 1'b1;
					tmr_val  = CNT_W'(DIS_OVER); // R12
				end
			end
			PH_DIS: begin
				if (tmr_done) begin
					phase_d = PH_NULL; // R1
				end
			end
			default: begin
				phase_d = PH_NULL;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			phase_q   <= PH_NULL;
			frame_q   <= '0;
			ref_cnt_q <= '0;
			pol_q     <= 1'b0;
			over_q    <= 1'b0;
			busy_q    <= 1'b0;
			result_q  <= '0;
			valid_q   <= 1'b0;
		end else begin
			phase_q   <= phase_d; // R16
			frame_q   <= frame_d;
			ref_cnt_q <= ref_cnt_d;
			pol_q     <= pol_d;
			over_q    <= over_d;
			busy_q    <= busy_d;
			result_q  <= result_d;
			valid_q   <= valid_d;
		end
	end

	// one-hot phase decode keeps only one switch set live
	assign offset_null_phase             = (phase_q == PH_NULL); // R17
	assign signal_integrate_phase        = (phase_q == PH_SIG); // R17
	assign reference_integrate_phase     = (phase_q == PH_REF); // R17
	assign integrator_discharge_phase    = (phase_q == PH_DIS); // R17
	assign inputs_shorted_to_common      = offset_null_phase; // R2
	assign ref_cap_charge                = offset_null_phase; // R2
	assign offset_storage_capacitor_loop = offset_null_phase; // R3
	assign analog_input_high_to_pin      = signal_integrate_phase; // R4
	assign analog_input_low_to_pin       = signal_integrate_phase; // R4
	assign analog_input_low_to_common    = reference_integrate_phase | integrator_discharge_phase; // R7 R10
	assign ref_cap_connect_pos           = reference_integrate_phase & ~pol_q; // R7 R8
	assign ref_cap_connect_neg           = reference_integrate_phase & pol_q; // R8
	assign discharge_loop                = integrator_discharge_phase; // R10
	assign polarity                      = pol_q;
	assign busy                          = busy_q;
	assign overrange                     = over_q;
	assign result_count                  = result_q;
	assign result_valid                  = valid_q;
endmodule

// ===== integ_model.sv
// Purpose: integrator and comparator in front of the sequencer
// Assumes: sign and cross_n are set during offset null
// Notes: comparator toggles in offset null, it never settles there
`timescale 1ns/100ps
module integ_model (
	input  wire logic        clk,
	input  wire logic        signal_integrate_phase,
	input  wire logic        reference_integrate_phase,
	input  wire logic        sign,
	input  wire logic [15:0] cross_n,
	output logic             comparator_positive
);
	logic [15:0] n_q   = 16'h0000;
	logic        tog_q = 1'b0;
	always @(posedge clk) begin
		n_q <= reference_integrate_phase ? n_q + 16'h0001 : 16'h0000;
		tog_q <= ~tog_q;
	end
	// ramp back toward zero crosses after cross_n reference clocks
	assign comparator_positive = signal_integrate_phase ? sign :
		reference_integrate_phase ? ((n_q < cross_n) == sign) : tog_q;
endmodule

// ===== phase_seq_pkg.sv
// Purpose: constants for the dual-slope phase sequencer
// Assumes: one conversion clock, synchronous active-high reset
// Notes: counts are in conversion clock pulses
// What this block does
// R1: run phases offset null, signal integrate, reference integrate, discharge, repeat.
// R2: offset null: inputs off pins, shorted to common, reference capacitor charged.
// R3: offset null: close buffer-integrator-comparator loop onto offset capacitor.
// R4: signal integrate: open null loop, remove short, connect inputs to pins.
// R5: signal integrate lasts a fixed number of clock periods.
// R6: at end of signal integrate latch comparator sign as polarity.
// R7: reference integrate: low input to common, high input across reference capacitor.
// R8: reference capacitor sense chosen from latched polarity.
// R9: count clocks until zero crossing; 10,000 counts equals full reference.
// R10: discharge: low input to common, loop to high input nulls integrator.
// R11: normal discharge lasts between 100 and 200 clock pulses.
// R12: discharge after overrange lasts 6200 clock pulses.
// R13: free-running cycles start every 40,002 clocks; offset null takes remainder.
// R14: busy from start of signal integrate to first clock after crossing.
// R15: flag overrange when reference count would exceed 20,000 without crossing.
// R16: everything changes on the clock; comparator sampled once per clock.
// R17: exactly one phase's switch set active at any time.
package phase_seq_pkg;
	localparam int CYCLE_CLOCKS      = 40002;
	localparam int INT_CLOCKS        = 10000;
	localparam int REF_MAX_CLOCKS    = 20001;
	localparam int OVER_LIMIT        = 20000;
	localparam int FULL_SCALE        = 10000;
	localparam int DISCH_CLOCKS      = 101;
	localparam int DISCH_OVER_CLOCKS = 6200;
	localparam int MIN_NULL_CLOCKS   = 1;
	localparam int CNT_W             = 16;
	typedef enum logic [1:0] {
		PH_NULL,
		PH_SIG,
		PH_REF,
		PH_DIS
	} phase_e;
endpackage

// ===== phase_timer.sv
// Purpose: down-counting phase timer
// Assumes: load has priority over counting
// Notes: done is high when the count stands at one
`timescale 1ns/100ps
module phase_timer #(
	parameter int W = 16
) (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	output logic              done
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (load) begin
			cnt_d = load_val;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign done = (cnt_q == W'(1));
endmodule

// ===== seq_properties.sv
// Purpose: port checks of the phase sequencer
// Assumes: one clock, srst synchronous active high
// Notes: ph_q is the length so far of the phase seen one clock earlier
`timescale 1ns/100ps
module seq_properties #(
	parameter int CYCLE    = 40002,
	parameter int INT_LEN  = 10000,
	parameter int DIS_LEN  = 101,
	parameter int DIS_OVER = 6200
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic offset_null_phase,
	input wire logic signal_integrate_phase,
	input wire logic reference_integrate_phase,
	input wire logic integrator_discharge_phase,
	input wire logic inputs_shorted_to_common,
	input wire logic ref_cap_charge,
	input wire logic analog_input_high_to_pin,
	input wire logic analog_input_low_to_pin,
	input wire logic offset_storage_capacitor_loop,
	input wire logic discharge_loop,
	input wire logic result_valid,
	input wire logic analog_input_low_to_common,
	input wire logic ref_cap_connect_pos,
	input wire logic ref_cap_connect_neg,
	input wire logic polarity,
	input wire logic busy,
	input wire logic overrange
);
	logic [3:0]  phs, phs_q;
	logic [15:0] ph_d, ph_q, per_d, per_q;
	logic        seen_d, seen_q, start;
	assign phs = {offset_null_phase, signal_integrate_phase, reference_integrate_phase, integrator_discharge_phase};
	assign start = signal_integrate_phase && !phs_q[2];
	always_comb begin
		ph_d = srst ? 16'h0000 : (phs != phs_q) ? 16'h0001 : ph_q + 16'h0001;
		per_d = srst ? 16'h0000 : start ? 16'h0001 : per_q + 16'h0001;
		seen_d = !srst && (seen_q || start);
	end
	always_ff @(posedge clk) begin
		phs_q <= phs;
		ph_q <= ph_d;
		per_q <= per_d;
		seen_q <= seen_d;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	sequence null_end; offset_null_phase ##1 !offset_null_phase; endsequence
	sequence sig_end; signal_integrate_phase ##1 !signal_integrate_phase; endsequence
	sequence ref_end; reference_integrate_phase ##1 !reference_integrate_phase; endsequence
	sequence dis_end; integrator_discharge_phase ##1 !integrator_discharge_phase; endsequence
	chk_one_phase: assert property ($onehot(phs)) else $error("phases not one-hot");
	chk_null_exit: assert property (null_end |-> signal_integrate_phase && busy) else $error("bad null exit");
	chk_sig_exit: assert property (sig_end |-> reference_integrate_phase && !overrange && ph_q == INT_LEN)
		else $error("bad integrate exit");
	chk_ref_exit: assert property (ref_end |-> integrator_discharge_phase && !busy) else $error("bad ref exit");
	chk_dis_len: assert property (dis_end |-> offset_null_phase && ph_q == ($past(overrange) ? DIS_OVER : DIS_LEN))
		else $error("bad discharge length");
	chk_cycle_period: assert property (start && seen_q |-> per_q == CYCLE) else $error("bad period");
	chk_null_set: assert property ({inputs_shorted_to_common, ref_cap_charge} == {2{offset_null_phase}})
		else $error("bad null switches");
	chk_pin_set: assert property (analog_input_high_to_pin == signal_integrate_phase) else $error("bad pins");
	chk_low_pin: assert property (analog_input_low_to_pin == signal_integrate_phase) else $error("bad low pin");
	chk_null_loop: assert property (offset_storage_capacitor_loop == offset_null_phase)
		else $error("bad null loop");
	chk_dis_loop: assert property (discharge_loop == integrator_discharge_phase) else $error("bad discharge loop");
	chk_busy_span: assert property (busy == (signal_integrate_phase || reference_integrate_phase))
		else $error("bad busy span");
	chk_valid_pulse: assert property (result_valid |-> integrator_discharge_phase ##1 !result_valid)
		else $error("bad result pulse");
	chk_ref_sense: assert property ({ref_cap_connect_pos, ref_cap_connect_neg} ==
		({2{reference_integrate_phase}} & {!polarity, polarity})) else $error("bad ref sense");
	chk_low_common: assert property (analog_input_low_to_common ==
		(reference_integrate_phase || integrator_discharge_phase)) else $error("bad low input");
	chk_pol_hold: assert property (reference_integrate_phase && $past(reference_integrate_phase) |-> $stable(polarity))
		else $error("polarity moved");
endmodule
bind dual_slope_phase_sequencer seq_properties #(.CYCLE(CYCLE), .INT_LEN(INT_LEN), .DIS_LEN(DIS_LEN),
	.DIS_OVER(DIS_OVER)) u_chk (.*);

// ===== test_dual_slope_phase_sequencer.sv
// Purpose: bench for the phase sequencer
// Assumes: shortened counts, integ_model as front end
// Notes: phase lengths and period are judged by the checker
`timescale 1ns/100ps
module test_dual_slope_phase_sequencer;
	import phase_seq_pkg::*;
	typedef struct {logic s; logic [15:0] n; logic [15:0] c; logic o;} row_s;
	row_s rows [4];
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic sign = 1'b1;
	logic [15:0] cross_n = 16'h0007;
	logic comparator_positive, offset_null_phase, signal_integrate_phase, reference_integrate_phase;
	logic integrator_discharge_phase, inputs_shorted_to_common, analog_input_high_to_pin, analog_input_low_to_pin;
	logic analog_input_low_to_common, ref_cap_charge, ref_cap_connect_pos, ref_cap_connect_neg;
	logic offset_storage_capacitor_loop, discharge_loop, polarity, busy, overrange, result_valid;
	logic [CNT_W-1:0] result_count;
	int err_total = 0;
	int tests_run = 0;
	dual_slope_phase_sequencer #(.CYCLE(200), .INT_LEN(20), .OVER_LIM(40), .DIS_LEN(5),
		.DIS_OVER(30)) u_dut (.*);
	integ_model u_front (.*);
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// returns in the first cycle of discharge (d=1) or of offset null (d=0)
	task automatic wait_for(input bit d);
		for (int k = 0; k < 400; k++) begin
			@(posedge clk);
			#1;
			if ((d ? integrator_discharge_phase : offset_null_phase) === 1'b1) return;
		end
		err_total++;
		$display("Error wait expected %b seen timeout", d);
		report_and_stop();
	endtask
	initial begin
		forever #25 clk = ~clk;
	end
	initial begin
		rows = '{'{1'b1, 16'h0007, 16'h0008, 1'b0}, '{1'b0, 16'h0026, 16'h0027, 1'b0},
			'{1'b1, 16'h003C, 16'h0000, 1'b1}, '{1'b0, 16'h0000, 16'h0001, 1'b0}};
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		foreach (rows[i]) begin
			@(posedge clk);
			sign <= rows[i].s;
			cross_n <= rows[i].n;
			wait_for(1'b1);
			if (!rows[i].o) check("count", rows[i].c, result_count);
			if (!rows[i].o) check("valid", 1'b1, result_valid);
			check("polarity", rows[i].s, polarity);
			check("overrange", rows[i].o, overrange);
			check("busy", 1'b0, busy);
			wait_for(1'b0);
			$display("row %0d done", i);
		end
		@(posedge clk);
		sign <= 1'b1;
		cross_n <= 16'h0003;
		wait_for(1'b1);
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check("reset phase", 1'b1, offset_null_phase);
		check("reset count", 16'h0000, result_count);
		check("reset polarity", 1'b0, polarity);
		check("reset busy", 1'b0, busy);
		check("reset overrange", 1'b0, overrange);
		@(posedge clk);
		srst <= 1'b0;
		wait_for(1'b1);
		check("count after reset", 16'h0004, result_count);
		$display("reset test done");
		report_and_stop();
	end
endmodule
